// File: logic/pmr_map.svh
// Register offsets, field positions, reset values and timing counts of the program memory read port.
`ifndef PMR_MAP_SVH
`define PMR_MAP_SVH
`define PMR_OFF_CONTROL     4'h0
`define PMR_OFF_DATA_LOW    4'h4
`define PMR_OFF_DATA_HIGH   4'h8
`define PMR_OFF_ADDR_LOW    4'hc
`define PMR_OFF_ADDR_HIGH   4'h0
`define PMR_BIT_TRIGGER     0
`define PMR_BIT_RESERVED    7
`define PMR_ADDR_HIGH_BYTE  3'd4
`define PMR_HIGH_ADDR_W     5
`define PMR_HIGH_DATA_W     6
`define PMR_CONTROL_RESET   8'h80
`define PMR_UNMAPPED_DATA   32'h0000_0000
`define PMR_INSTR_CYCLES    2
`define PMR_CLK_PER_INSTR   4
`define PMR_READ_CYCLES     (`PMR_INSTR_CYCLES * `PMR_CLK_PER_INSTR)
`endif

// File: logic/pmr_pkg.sv
// Types shared by the program memory read port.
`default_nettype none
package pmr_pkg;
    typedef enum logic [1:0] {
        PMR_IDLE  = 2'b00,
        PMR_FETCH = 2'b01,
        PMR_LOAD  = 2'b11
    } pmr_state_t;
    typedef logic [12:0] pmr_word_addr_t;
    typedef logic [13:0] pmr_word_value_t;
endpackage
`default_nettype wire

// File: logic/pmr_flash_port.sv
// Sequencer that fetches one word from the flash array and times the read.
`timescale 1ns/1ps
`default_nettype none
`include "pmr_map.svh"
module pmr_flash_port
    import pmr_pkg::*;
#(
    parameter int READ_CYCLES = `PMR_READ_CYCLES
) (
    // Clock and reset.
    input  wire logic            mclk,
    input  wire logic            reset_n,
    // Request from the register file.
    input  wire logic            start,
    input  wire pmr_word_addr_t  addr,
    output logic                 done,
    output pmr_word_value_t      value,
    // Flash array side.
    output logic                 flash_rd_en,
    output pmr_word_addr_t       flash_addr,
    input  wire pmr_word_value_t flash_data
);
    localparam int CW = $clog2(READ_CYCLES + 1);
    pmr_state_t     state_r;
    logic [CW-1:0]  count_r;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_r <= PMR_IDLE;
            count_r <= '0;
        end else begin
            unique case (state_r)
                PMR_IDLE: begin
                    if (start) begin
                        state_r <= PMR_FETCH;
                        count_r <= CW'(READ_CYCLES - 2);
                    end
                end
                PMR_FETCH: begin
                    if (count_r == '0) begin
                        state_r <= PMR_LOAD;
                    end else begin
                        count_r <= count_r - 1'b1;
                    end
                end
                PMR_LOAD: begin
                    state_r <= PMR_IDLE;
                end
                default: begin
                    state_r <= PMR_IDLE;
                end
            endcase
        end
    end

    // The address is latched at start so a later write cannot disturb the read in flight.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            flash_addr  <= '0;
            flash_rd_en <= 1'b0;
        end else begin
            if (start && state_r == PMR_IDLE) begin
                flash_addr <= addr;
            end
            flash_rd_en <= (state_r == PMR_IDLE && start) || state_r == PMR_FETCH;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            done  <= 1'b0;
            value <= '0;
        end else begin
            done <= (state_r == PMR_LOAD);
            if (state_r == PMR_FETCH && count_r == '0) begin
                value <= flash_data;
            end
        end
    end
endmodule // pmr_flash_port
`default_nettype wire

// File: logic/pmr_read_port.sv
// Program memory read port: Avalon-MM register file and flash read control.
//
// Contract
// R1: Program memory can be read at any time during normal operation, with no supply-dependent gating.
// R2: The word address is the high address register bits 4..0 joined above the low address register.
// R3: Writing one to bit 0 of the read-control register starts a program memory read.
// R4: A read takes two instruction cycles, and the processor must skip the second instruction after the trigger.
// R5: Software places two no-operation instructions after setting the trigger.
// R6: On completion word bits 13..8 go to high data bits 5..0 and bits 7..0 to the low data register.
// R7: Hardware clears the trigger bit, and a software write of zero to it does nothing.
// R8: Bit 7 of the read-control register reads as one and resets to one.
// R9: Read-control bits 6..1, high data bits 7..6 and high address bits 7..5 read as zero.
// R10: Code protection never blocks reads through this port.
// R11: Address and data registers are read/write with undefined reset contents, and the trigger resets to zero.
// R12: The low address register holds word address bits 7..0 and is read/write.
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pmr_map.svh"
module pmr_read_port
    import pmr_pkg::*;
#(
    parameter int READ_CYCLES = `PMR_READ_CYCLES
) (
    // Clock and reset.
    input  wire logic            mclk,
    input  wire logic            reset_n,
    // Avalon-MM slave.
    input  wire logic [4:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    input  wire logic [3:0]      avs_byteenable,
    output logic [31:0]          avs_readdata,
    output logic                 avs_waitrequest,
    // Core side.
    output logic                 skip_instr,
    // Flash array side.
    output logic                 flash_rd_en,
    output pmr_word_addr_t       flash_addr,
    input  wire pmr_word_value_t flash_data
);
    logic [7:0]                    addr_low_r;
    logic [`PMR_HIGH_ADDR_W-1:0]   addr_high_r;
    logic [7:0]                    data_low_r;
    logic [`PMR_HIGH_DATA_W-1:0]   data_high_r;
    logic                          trigger_r;
    logic                          ack_r;
    logic                          skip_r;
    logic                          done;
    pmr_word_value_t               value;
    logic                          access;
    logic                          wr_hit;
    logic                          start;
    logic [4:0]                    word_sel;

    // One wait cycle on every access, then the answer in the next.
    assign access   = (avs_read || avs_write) && !ack_r;
    assign wr_hit   = avs_write && ack_r && avs_byteenable[0];
    assign word_sel = avs_address;
    // A new read only starts while none is running.
    assign start    = wr_hit && word_sel == {1'b0, `PMR_OFF_CONTROL}
                      && avs_writedata[`PMR_BIT_TRIGGER] && !trigger_r; // R3

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= access;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !access;
        end
    end

    // Trigger: set by software, cleared only by hardware; a set in the done cycle is dropped, as the trigger is still high.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            trigger_r <= 1'b0; // R11
        end else if (start) begin
            trigger_r <= 1'b1; // R3
        end else if (done) begin
            trigger_r <= 1'b0; // R7
        end
    end

    // Address and data registers hold no reset value.
    always_ff @(posedge mclk) begin
        if (wr_hit && word_sel == {1'b0, `PMR_OFF_ADDR_LOW}) begin
            addr_low_r <= avs_writedata[7:0]; // R12
        end
        if (wr_hit && word_sel == {1'b1, `PMR_OFF_ADDR_HIGH}) begin
            addr_high_r <= avs_writedata[`PMR_HIGH_ADDR_W-1:0]; // R11
        end
    end

    always_ff @(posedge mclk) begin
        if (done) begin
            data_low_r  <= value[7:0]; // R6
            data_high_r <= value[13:8]; // R6
        end else begin
            if (wr_hit && word_sel == {1'b0, `PMR_OFF_DATA_LOW}) begin
                data_low_r <= avs_writedata[7:0]; // R11
            end
            if (wr_hit && word_sel == {1'b0, `PMR_OFF_DATA_HIGH}) begin
                data_high_r <= avs_writedata[`PMR_HIGH_DATA_W-1:0]; // R11
            end
        end
    end

    // Read mux; unmapped words and unimplemented bits answer zero.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            avs_readdata <= `PMR_UNMAPPED_DATA;
        end else if (access && avs_read) begin
            case (word_sel)
                {1'b0, `PMR_OFF_CONTROL}:   avs_readdata <= {24'h0, 1'b1, 6'h0, trigger_r}; // R8 R9
                {1'b0, `PMR_OFF_DATA_LOW}:  avs_readdata <= {24'h0, data_low_r};
                {1'b0, `PMR_OFF_DATA_HIGH}: avs_readdata <= {26'h0, data_high_r}; // R9
                {1'b0, `PMR_OFF_ADDR_LOW}:  avs_readdata <= {24'h0, addr_low_r};
                {1'b1, `PMR_OFF_ADDR_HIGH}: avs_readdata <= {27'h0, addr_high_r}; // R9
                default:                    avs_readdata <= `PMR_UNMAPPED_DATA;
            endcase
        end
    end

    // Core is told to drop the instruction that collides with the fetch.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            skip_r     <= 1'b0;
            skip_instr <= 1'b0;
        end else begin
            skip_r     <= start;
            skip_instr <= skip_r; // R4
        end
    end

    // No protection or supply gating sits in the fetch path.
    pmr_flash_port #(
        .READ_CYCLES (READ_CYCLES)
    ) u_flash (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .start       (start), // R1 R10
        .addr        ({addr_high_r, addr_low_r}), // R2
        .done        (done),
        .value       (value),
        .flash_rd_en (flash_rd_en),
        .flash_addr  (flash_addr),
        .flash_data  (flash_data)
    );
endmodule // pmr_read_port
`default_nettype wire

// File: dv/pmr_read_port_monitor.sv
// Bus, timing and read-value checks on the program memory read port.
`timescale 1ns/1ps
`default_nettype none
module pmr_read_port_monitor
    import pmr_pkg::*;
#(
    parameter int READ_CYCLES = 8
) (
    // Clock and reset.
    input wire logic           mclk,
    input wire logic           reset_n,
    // Bus.
    input wire logic [4:0]     avs_address,
    input wire logic           avs_read,
    input wire logic           avs_write,
    input wire logic [31:0]    avs_readdata,
    input wire logic           avs_waitrequest,
    // Core and array.
    input wire logic           skip_instr,
    input wire logic           flash_rd_en,
    input wire pmr_word_addr_t flash_addr
);
    int run_r;
    logic done_rd;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    assign done_rd = avs_read && !avs_waitrequest;
    always_ff @(posedge mclk) begin
        run_r <= (!reset_n || !flash_rd_en) ? 0 : run_r + 1;
    end
    a_req_answered: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest) else $error("no answer");
    a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
    a_read_length: assert property ($fell(flash_rd_en) |-> run_r == READ_CYCLES) else $error("read length");
    a_skip_single: assert property (skip_instr |=> !skip_instr) else $error("skip width");
    a_skip_timing: assert property ($rose(flash_rd_en) |-> ##1 skip_instr) else $error("skip late");
    a_addr_held: assert property (flash_rd_en && $past(flash_rd_en) |-> $stable(flash_addr)) else $error("addr moved");
    a_control_bits: assert property (done_rd && avs_address == 5'h00 |-> avs_readdata[7:1] == 7'h40) else $error("control");
    a_high_zero: assert property (done_rd && avs_address == 5'h08 |-> avs_readdata[7:6] == 2'h0) else $error("data hi");
    a_unmapped_zero: assert property (done_rd && (avs_address[1:0] != 2'h0 || avs_address > 5'h10) |->
        avs_readdata == 32'h0) else $error("unmapped");
endmodule // pmr_read_port_monitor
bind pmr_read_port pmr_read_port_monitor #(.READ_CYCLES(READ_CYCLES)) u_mon (.mclk(mclk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .skip_instr(skip_instr), .flash_rd_en(flash_rd_en), .flash_addr(flash_addr));
`default_nettype wire

// File: dv/pmr_flash_model.sv
// Behavioural flash array answering every word address.
`timescale 1ns/1ps
`default_nettype none
module pmr_flash_model
    import pmr_pkg::*;
(
    input  wire logic           flash_rd_en,
    input  wire pmr_word_addr_t flash_addr,
    output pmr_word_value_t     flash_data
);
    // No protection gating; outside a read the lines show the inverse so stale data is not mistaken for good.
    assign flash_data = flash_rd_en ? ({flash_addr, 1'b1} ^ 14'h2b4c) : ~({flash_addr, 1'b1} ^ 14'h2b4c);
endmodule // pmr_flash_model
`default_nettype wire

// File: dv/pmr_read_port_tb.sv
// Self-checking bench of the program memory read port.
`timescale 1ns/1ps
`default_nettype none
module pmr_read_port_tb;
    import pmr_pkg::*;
    localparam int RC = 8;
    logic mclk = 0, reset_n = 0, avs_read = 0, avs_write = 0, skip_instr, flash_rd_en, avs_waitrequest;
    logic [4:0] avs_address = 0;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_writedata = 0, avs_readdata, q;
    logic [15:0] seed;
    pmr_word_addr_t flash_addr, a;
    pmr_word_value_t flash_data, e;
    int n_errors = 0, n_compared = 0, n_skip = 0;
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (skip_instr === 1'b1) n_skip++;
    pmr_read_port #(.READ_CYCLES(RC)) uut (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .skip_instr(skip_instr),
        .flash_rd_en(flash_rd_en), .flash_addr(flash_addr), .flash_data(flash_data));
    pmr_flash_model u_flash (.flash_rd_en(flash_rd_en), .flash_addr(flash_addr), .flash_data(flash_data));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic pmr_word_value_t exp_word(input pmr_word_addr_t ad);
        return {ad, 1'b1} ^ 14'h2b4c;
    endfunction
    task automatic bus(input logic w, input logic [4:0] ad, input logic [7:0] d);
        avs_address <= ad;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // An idle edge keeps the next call from driving the strobes again in this time step.
        @(posedge mclk);
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        complete_run;
    end
    initial begin
        seed = 16'h1d64;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        bus(0, 5'h00, 8'h00);
        chk("control", 32'h80, q);
        bus(1, 5'h04, 8'h5a);
        bus(0, 5'h04, 8'h00);
        chk("data_low", 32'h5a, q);
        avs_byteenable <= 4'he;
        bus(1, 5'h04, 8'ha5);
        avs_byteenable <= 4'h1;
        bus(0, 5'h04, 8'h00);
        chk("lane_off", 32'h5a, q);
        bus(1, 5'h08, 8'hff);
        bus(0, 5'h08, 8'h00);
        chk("data_high", 32'h3f, q);
        bus(1, 5'h05, 8'h77);
        bus(0, 5'h05, 8'h00);
        chk("unmapped", 32'h0, q);
        bus(1, 5'h00, 8'h80);
        bus(0, 5'h00, 8'h00);
        chk("zero_write", 32'h80, q);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            a = (i == 0) ? 13'h1fff : (i == 1) ? 13'h0000 : seed[12:0];
            e = exp_word(a);
            bus(1, 5'h0c, a[7:0]);
            bus(1, 5'h10, {3'h7, a[12:8]});
            bus(1, 5'h00, 8'h81);
            @(posedge mclk);
            chk("flash_addr", {19'h0, a}, {19'h0, flash_addr});
            repeat (RC + 1) @(posedge mclk);
            bus(0, 5'h00, 8'h00);
            chk("trigger_clear", 32'h80, q);
            bus(0, 5'h04, 8'h00);
            chk("word_low", {24'h0, e[7:0]}, q);
            bus(0, 5'h08, 8'h00);
            chk("word_high", {26'h0, e[13:8]}, q);
            bus(0, 5'h10, 8'h00);
            chk("addr_high", {27'h0, a[12:8]}, q);
            bus(0, 5'h0c, 8'h00);
            chk("addr_low", {24'h0, a[7:0]}, q);
        end
        chk("skip_count", 32'd6, n_skip);
        $display("test reads done");
        complete_run;
    end
endmodule // pmr_read_port_tb
`default_nettype wire
